// ---- core/ckg_pkg.sv ----
// Package with constants, register map and state encodings of the clock output control block.
package ckg_pkg;

  // ****************************************************************
  // Outputs and serial target
  // ****************************************************************
  localparam int        NUM_OUT         = 9;
  localparam int        NUM_PIN_OE      = 4;
  localparam logic [7:0] TARGET_ADDR8   = 8'hd6;
  localparam logic [6:0] TARGET_ADDR7   = TARGET_ADDR8[7:1];
  localparam int        CMD_BYTE_MODE   = 7;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_RESERVED   = 8'h00;
  localparam logic [7:0] OFS_OE_LOW     = 8'h01;
  localparam logic [7:0] OFS_OE_HIGH    = 8'h02;
  localparam logic [7:0] REG_COUNT      = 8'h03;
  localparam logic [7:0] RST_RESERVED   = 8'h00;
  localparam logic [7:0] RST_OE_LOW     = 8'h17;
  localparam logic [7:0] RST_OE_HIGH    = 8'hf8;
  localparam int        OE_LOW_BIT_0    = 4;
  localparam int        OE_LOW_BIT_1    = 2;
  localparam int        OE_LOW_BIT_2    = 1;
  localparam int        OE_LOW_BIT_3    = 0;
  localparam int        OE_HIGH_BIT_4   = 7;

  // ****************************************************************
  // Spread setting and synchroniser lanes
  // ****************************************************************
  localparam int        SPREAD_DOWN_PPM = 5000;
  localparam int        NUM_SYNC        = 11;
  localparam int        SY_REF          = 10;
  localparam int        SY_SCL          = 9;
  localparam int        SY_SDA          = 8;
  localparam int        SY_PWR          = 7;
  localparam int        SY_SPREAD       = 6;
  localparam int        SY_GRP68        = 5;
  localparam int        SY_GRP45        = 4;

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    PWR_WAIT_GOOD = 2'b00,
    PWR_RUN       = 2'b01,
    PWR_DOWN      = 2'b10
  } ckg_pwr_e;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX   = 3'b001,
    I2C_ACK  = 3'b010,
    I2C_TX   = 3'b011,
    I2C_MACK = 3'b100
  } ckg_i2c_e;

  typedef enum logic [1:0] {
    PH_ADDR  = 2'b00,
    PH_CMD   = 2'b01,
    PH_COUNT = 2'b10,
    PH_DATA  = 2'b11
  } ckg_phase_e;

endpackage

// ---- core/ckg_out_gate.sv ----
// Glitch-free gate for one output clock, enable retimed to the output clock's falling edge.
`timescale 1ns/10ps
module ckg_out_gate (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Synchronised reference clock
  input  wire logic ref_lvl,
  input  wire logic ref_fall,
  // Requested enable and gated output
  input  wire logic en_req,
  output logic      out
);

  logic en_s1;
  logic en_eff;

  // Enable moves only on a falling output edge, so a pulse is never cut or stretched.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_s1  <= 1'b0;
      en_eff <= 1'b0;
    end else if (ref_fall) begin
      en_s1  <= en_req;
      en_eff <= en_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out <= 1'b0;
    end else begin
      out <= ref_lvl & en_eff;
    end
  end

  a_en_moves_low: assert property (@(posedge clk) disable iff (rst) $changed(en_eff) |-> !ref_lvl)
    else $error("Output enable changed while reference high.");

  a_out_needs_en: assert property (@(posedge clk) disable iff (rst) out |-> $past(en_eff))
    else $error("Output high without effective enable.");

  a_restart_bound: assert property (@(posedge clk) disable iff (rst)
    $rose(en_req) ##1 en_req [*3] |-> ##[0:60] en_eff)
    else $error("Output not restarted within six output cycles.");

endmodule

// ---- core/ckg_clock_ctrl.sv ----
// Clock output control: power-good/power-down pin, output gating, spread select, serial target.
// Functional notes
// - Pin is power-good until first sampled high.
// - Power-good low: outputs off, serial logic alive.
// - After power-good, pin low means power-down.
// - Power-down stops outputs without glitches.
// - Power-down: outputs low, oscillator, serial off.
// - Power-down release restarts outputs in 2-6 cycles.
// - Output runs only if pin and bit high.
// - Enable bits reset to one.
// - Re-enabled output restarts cleanly in 2-6 cycles.
// - Disabled output stops at boundary, held low.
// - Spread pin high selects down-spread.
// - All registers load defaults at reset.
// - Byte/block read and write supported.
// - Block access ascending, MSB first, stop anywhere.
// - Byte operation uses command code index.
// - Target answers only address 8'hd6.
// - Block write: command, count, data, all acked.
// - Block read: count then data, master NACKs last.
// - Byte write: command and data acked.
// - Byte read: one byte, master NACKs.
// - Byte 1 holds enables of outputs 0-3.
// - Byte 0 reserved, read/write, resets zero.
// - Byte 2 holds enables of outputs 4-8.
// - Group pins gate outputs 4-5 and 6-8.
`timescale 1ns/10ps
module ckg_clock_ctrl (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Reference clock from the oscillator
  input  wire logic                         ref_clk_pin,
  // Power and spread pins
  input  wire logic                         power_good_or_down_pin,
  input  wire logic                         spread_enable_pin,
  // Output enable pins
  input  wire logic [ckg_pkg::NUM_PIN_OE-1:0] out_en_pin,
  input  wire logic                         group_4_5_gate_pin,
  input  wire logic                         group_6_8_gate_pin,
  // Serial control bus
  input  wire logic                         scl_pin,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_n,
  // Clock outputs and analog controls
  output logic [ckg_pkg::NUM_OUT-1:0]       clk_out,
  output logic                              spread_down_en,
  output logic                              osc_enable
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [ckg_pkg::NUM_SYNC-1:0] sync1;
  logic [ckg_pkg::NUM_SYNC-1:0] sync2;
  logic [2:0]                   sync3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {ref_clk_pin, scl_pin, sda_in, power_good_or_down_pin, spread_enable_pin,
                group_6_8_gate_pin, group_4_5_gate_pin, out_en_pin};
      sync2 <= sync1;
      sync3 <= {sync2[ckg_pkg::SY_REF], sync2[ckg_pkg::SY_SCL], sync2[ckg_pkg::SY_SDA]};
    end
  end

  logic ref_lvl;
  logic ref_fall;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic pwr_s;

  assign ref_lvl   = sync2[ckg_pkg::SY_REF];
  assign ref_fall  = sync3[2] & ~ref_lvl;
  assign scl_s     = sync2[ckg_pkg::SY_SCL];
  assign sda_s     = sync2[ckg_pkg::SY_SDA];
  assign scl_rise  = scl_s & ~sync3[1];
  assign scl_fall  = ~scl_s & sync3[1];
  assign start_det = scl_s & sync3[1] & sync3[0] & ~sda_s;
  assign stop_det  = scl_s & sync3[1] & ~sync3[0] & sda_s;
  assign pwr_s     = sync2[ckg_pkg::SY_PWR];

  // ****************************************************************
  // Power state
  // ****************************************************************
  // The power-down pin is asynchronous; it is sampled here and the output
  // gates then stop each clock on its own low phase, so no runt pulse leaves.
  ckg_pkg::ckg_pwr_e pstate;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pstate <= ckg_pkg::PWR_WAIT_GOOD;
    end else begin
      unique case (pstate)
        ckg_pkg::PWR_WAIT_GOOD: if (pwr_s) begin
          pstate <= ckg_pkg::PWR_RUN;
        end
        ckg_pkg::PWR_RUN: if (!pwr_s) begin
          pstate <= ckg_pkg::PWR_DOWN;
        end
        ckg_pkg::PWR_DOWN: if (pwr_s) begin
          pstate <= ckg_pkg::PWR_RUN;
        end
        default: pstate <= ckg_pkg::PWR_WAIT_GOOD;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_enable     <= 1'b1;
      spread_down_en <= 1'b0;
      sda_out        <= 1'b0;
    end else begin
      osc_enable     <= (pstate != ckg_pkg::PWR_DOWN);
      spread_down_en <= sync2[ckg_pkg::SY_SPREAD];
      sda_out        <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] reg_reserved;
  logic [7:0] reg_oe_low;
  logic [7:0] reg_oe_high;
  logic       wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_reserved <= ckg_pkg::RST_RESERVED;
      reg_oe_low   <= ckg_pkg::RST_OE_LOW;
      reg_oe_high  <= ckg_pkg::RST_OE_HIGH;
    end else if (wr_stb) begin
      if (wr_idx == ckg_pkg::OFS_RESERVED) begin
        reg_reserved <= wr_data;
      end
      if (wr_idx == ckg_pkg::OFS_OE_LOW) begin
        reg_oe_low <= wr_data;
      end
      if (wr_idx == ckg_pkg::OFS_OE_HIGH) begin
        reg_oe_high <= wr_data;
      end
    end
  end

  function automatic logic [7:0] rd_reg(input logic [7:0] idx, input logic [7:0] r0,
                                        input logic [7:0] r1, input logic [7:0] r2);
    logic [7:0] val;
    val = 8'h00;
    if (idx == ckg_pkg::OFS_RESERVED) val = r0;
    if (idx == ckg_pkg::OFS_OE_LOW) val = r1;
    if (idx == ckg_pkg::OFS_OE_HIGH) val = r2;
    return val;
  endfunction

  // ****************************************************************
  // Output gating
  // ****************************************************************
  logic [ckg_pkg::NUM_OUT-1:0] oe_bits;
  logic [ckg_pkg::NUM_OUT-1:0] oe_pins;
  logic [ckg_pkg::NUM_OUT-1:0] en_req;

  assign oe_bits = {reg_oe_high[ckg_pkg::OE_HIGH_BIT_4-4], reg_oe_high[ckg_pkg::OE_HIGH_BIT_4-3],
                    reg_oe_high[ckg_pkg::OE_HIGH_BIT_4-2], reg_oe_high[ckg_pkg::OE_HIGH_BIT_4-1],
                    reg_oe_high[ckg_pkg::OE_HIGH_BIT_4], reg_oe_low[ckg_pkg::OE_LOW_BIT_3],
                    reg_oe_low[ckg_pkg::OE_LOW_BIT_2], reg_oe_low[ckg_pkg::OE_LOW_BIT_1],
                    reg_oe_low[ckg_pkg::OE_LOW_BIT_0]};
  assign oe_pins = {{3{sync2[ckg_pkg::SY_GRP68]}}, {2{sync2[ckg_pkg::SY_GRP45]}},
                    sync2[ckg_pkg::NUM_PIN_OE-1:0]};

  genvar gi;
  generate
    for (gi = 0; gi < ckg_pkg::NUM_OUT; gi++) begin : g_out
      // Either the pin or the bit low stops the output; only run state lets it go.
      assign en_req[gi] = oe_pins[gi] & oe_bits[gi] & (pstate == ckg_pkg::PWR_RUN);
      ckg_out_gate u_gate (
        .clk      (clk),
        .rst      (rst),
        .ref_lvl  (ref_lvl),
        .ref_fall (ref_fall),
        .en_req   (en_req[gi]),
        .out      (clk_out[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Serial target
  // ****************************************************************
  ckg_pkg::ckg_i2c_e   i2c_st;
  ckg_pkg::ckg_phase_e phase;
  logic [3:0]          bit_cnt;
  logic [7:0]          shreg;
  logic [7:0]          ptr;
  logic                byte_mode;
  logic                send_count;
  logic                tx_next;
  logic                master_ack;
  logic [7:0]          tx_byte;

  // A block read first returns the register count, then bytes from the pointer upward.
  assign tx_byte = send_count ? ckg_pkg::REG_COUNT : rd_reg(ptr, reg_reserved, reg_oe_low, reg_oe_high);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i2c_st     <= ckg_pkg::I2C_IDLE;
      phase      <= ckg_pkg::PH_ADDR;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      ptr        <= 8'h00;
      byte_mode  <= 1'b0;
      send_count <= 1'b0;
      tx_next    <= 1'b0;
      master_ack <= 1'b0;
      sda_oe_n   <= 1'b1;
      wr_stb     <= 1'b0;
      wr_idx     <= 8'h00;
      wr_data    <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (pstate == ckg_pkg::PWR_DOWN) begin
        i2c_st   <= ckg_pkg::I2C_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_det) begin
        i2c_st   <= ckg_pkg::I2C_RX;
        phase    <= ckg_pkg::PH_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_det) begin
        i2c_st   <= ckg_pkg::I2C_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        unique case (i2c_st)
          ckg_pkg::I2C_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ckg_pkg::I2C_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == ckg_pkg::BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              tx_next <= 1'b0;
              unique case (phase)
                ckg_pkg::PH_ADDR: begin
                  if (shreg[7:1] == ckg_pkg::TARGET_ADDR7) begin
                    i2c_st   <= ckg_pkg::I2C_ACK;
                    sda_oe_n <= 1'b0;
                    tx_next  <= shreg[0];
                    phase    <= ckg_pkg::PH_CMD;
                  end else begin
                    i2c_st <= ckg_pkg::I2C_IDLE;
                  end
                end
                ckg_pkg::PH_CMD: begin
                  byte_mode  <= shreg[ckg_pkg::CMD_BYTE_MODE];
                  send_count <= ~shreg[ckg_pkg::CMD_BYTE_MODE];
                  ptr        <= {1'b0, shreg[6:0]};
                  phase      <= shreg[ckg_pkg::CMD_BYTE_MODE] ? ckg_pkg::PH_DATA : ckg_pkg::PH_COUNT;
                  i2c_st     <= ckg_pkg::I2C_ACK;
                  sda_oe_n   <= 1'b0;
                end
                ckg_pkg::PH_COUNT: begin
                  phase    <= ckg_pkg::PH_DATA;
                  i2c_st   <= ckg_pkg::I2C_ACK;
                  sda_oe_n <= 1'b0;
                end
                ckg_pkg::PH_DATA: begin
                  wr_stb   <= 1'b1;
                  wr_idx   <= ptr;
                  wr_data  <= shreg;
                  ptr      <= ptr + 8'h01;
                  i2c_st   <= ckg_pkg::I2C_ACK;
                  sda_oe_n <= 1'b0;
                end
              endcase
            end
          end
          ckg_pkg::I2C_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (tx_next) begin
                shreg    <= tx_byte;
                sda_oe_n <= tx_byte[7];
                i2c_st   <= ckg_pkg::I2C_TX;
                if (send_count) begin
                  send_count <= 1'b0;
                end else begin
                  ptr <= ptr + 8'h01;
                end
              end else begin
                sda_oe_n <= 1'b1;
                i2c_st   <= ckg_pkg::I2C_RX;
              end
            end
          end
          ckg_pkg::I2C_TX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == ckg_pkg::BITS_PER_BYTE) begin
                sda_oe_n <= 1'b1;
                i2c_st   <= ckg_pkg::I2C_MACK;
              end else begin
                sda_oe_n <= shreg[7];
              end
            end
          end
          ckg_pkg::I2C_MACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (master_ack) begin
                shreg    <= tx_byte;
                sda_oe_n <= tx_byte[7];
                i2c_st   <= ckg_pkg::I2C_TX;
                if (send_count) begin
                  send_count <= 1'b0;
                end else begin
                  ptr <= ptr + 8'h01;
                end
              end else begin
                i2c_st <= ckg_pkg::I2C_IDLE;
              end
            end
          end
          default: i2c_st <= ckg_pkg::I2C_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_good_to_run: assert property (@(posedge clk) disable iff (rst)
    pstate == ckg_pkg::PWR_WAIT_GOOD && pwr_s |=> pstate == ckg_pkg::PWR_RUN)
    else $error("Power-good high did not enter run.");

  a_run_to_down: assert property (@(posedge clk) disable iff (rst)
    pstate == ckg_pkg::PWR_RUN && !pwr_s |=> pstate == ckg_pkg::PWR_DOWN)
    else $error("Power-down pin low did not enter power-down.");

  a_wait_no_out: assert property (@(posedge clk) disable iff (rst)
    pstate == ckg_pkg::PWR_WAIT_GOOD |-> en_req == '0 && osc_enable)
    else $error("Output requested before power-good.");

  a_down_quiet: assert property (@(posedge clk) disable iff (rst)
    pstate == ckg_pkg::PWR_DOWN ##1 pstate == ckg_pkg::PWR_DOWN |-> i2c_st == ckg_pkg::I2C_IDLE && sda_oe_n && !osc_enable)
    else $error("Serial target or oscillator active in power-down.");

  a_down_out_low: assert property (@(posedge clk) disable iff (rst)
    $rose(pstate == ckg_pkg::PWR_DOWN) |-> ##[1:60] clk_out == '0)
    else $error("Outputs not stopped after power-down.");

  a_pin_gates_out: assert property (@(posedge clk) disable iff (rst)
    !oe_pins[0] |-> !en_req[0])
    else $error("Output 0 requested with its pin low.");

  a_addr_nack: assert property (@(posedge clk) disable iff (rst)
    i2c_st == ckg_pkg::I2C_RX && phase == ckg_pkg::PH_ADDR && scl_fall && !start_det && !stop_det &&
    bit_cnt == ckg_pkg::BITS_PER_BYTE && shreg[7:1] != ckg_pkg::TARGET_ADDR7 &&
    pstate != ckg_pkg::PWR_DOWN |=> i2c_st == ckg_pkg::I2C_IDLE && sda_oe_n)
    else $error("Foreign address acknowledged.");

  a_write_ascend: assert property (@(posedge clk) disable iff (rst)
    wr_stb |-> ptr == wr_idx + 8'h01)
    else $error("Block write pointer not ascending.");

  a_reset_dflt: assert property (@(posedge clk) $fell(rst) |-> reg_oe_low == ckg_pkg::RST_OE_LOW &&
    reg_oe_high == ckg_pkg::RST_OE_HIGH && reg_reserved == ckg_pkg::RST_RESERVED)
    else $error("Registers not at defaults after reset.");

  a_spread_track: assert property (@(posedge clk) disable iff (rst)
    sync2[ckg_pkg::SY_SPREAD] [*2] |-> spread_down_en)
    else $error("Spread select does not follow its pin.");

endmodule

// ---- tb/ckg_bus_master.sv ----
// Serial bus master model driving the clock line and the open-drain data line.
`timescale 1ns/10ps
module ckg_bus_master (
  // Bench clock
  input  wire logic clk,
  // Serial bus, data released high by the pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Waits run from clock edges so every pin change lands 1 ns after an edge.
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Phases of 1 us; data moves 200 ns after the clock line falls so the target's hold is kept.
  task automatic start();
    wt(20);
    sda_drv = 1'b1;
    wt(80);
    scl = 1'b1;
    wt(100);
    sda_drv = 1'b0;
    wt(100);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(20);
    sda_drv = 1'b0;
    wt(80);
    scl = 1'b1;
    wt(100);
    sda_drv = 1'b1;
    wt(100);
  endtask
  // Nine bit slots, most significant first; a 1 releases the line so the target can drive it.
  task automatic bits(input logic [8:0] o, output logic [8:0] i);
    for (int b = 8; b >= 0; b--) begin
      wt(20);
      sda_drv = o[b];
      wt(80);
      scl = 1'b1;
      wt(100);
      i[b] = sda_line;
      scl = 1'b0;
    end
  endtask
endmodule

// ---- tb/ckg_clock_ctrl_tb_top.sv ----
// Self-checking testbench of the clock output control block.
`timescale 1ns/10ps
module ckg_clock_ctrl_tb_top;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic        ref_clk_pin = 1'b0;
  logic        pwr         = 1'b0;
  logic        spread      = 1'b0;
  logic [3:0]  oe_pin      = 4'hf;
  logic        g45         = 1'b1;
  logic        g68         = 1'b1;
  logic        good        = 1'b0;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe_n;
  logic        spread_down_en;
  logic        osc_enable;
  logic [8:0]  clk_out;
  logic [31:0] rnd;
  logic [7:0]  mreg [3] = '{8'h00, 8'h17, 8'hf8};
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          seed        = 32'h1292c743;
  wire         sda         = sda_drv & (sda_oe_n | sda_out);

  always #5 clk = ~clk;
  // The reference clock is offset so its edges never meet the bench clock's.
  initial begin
    #3;
    forever #40 ref_clk_pin = ~ref_clk_pin;
  end

  ckg_clock_ctrl i_ckg_clock_ctrl (.clk(clk), .rst(rst), .ref_clk_pin(ref_clk_pin),
    .power_good_or_down_pin(pwr), .spread_enable_pin(spread), .out_en_pin(oe_pin),
    .group_4_5_gate_pin(g45), .group_6_8_gate_pin(g68), .scl_pin(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .clk_out(clk_out), .spread_down_en(spread_down_en),
    .osc_enable(osc_enable));
  ckg_bus_master i_ckg_bus_master (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda));

  // ****************************************************************
  // Comparison and bus tasks
  // ****************************************************************
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wb(logic [7:0] d, logic ack_exp);
    logic [8:0] r;
    i_ckg_bus_master.bits({d, 1'b1}, r);
    chk("ack", {15'h0, r[0]}, {15'h0, ~ack_exp});
  endtask
  task automatic head(logic [7:0] cmd);
    i_ckg_bus_master.start();
    wb(ckg_pkg::TARGET_ADDR8, 1'b1);
    wb(cmd, 1'b1);
  endtask
  task automatic addr_only(logic [7:0] a, logic ack_exp);
    i_ckg_bus_master.start();
    wb(a, ack_exp);
    i_ckg_bus_master.stop();
  endtask
  // Block writes carry the count first; the model files data from the command index upward.
  task automatic reg_write(logic [7:0] cmd, logic [7:0] q[$]);
    int idx;
    head(cmd);
    foreach (q[k]) begin
      wb(q[k], 1'b1);
      idx = cmd[6:0] + k - (cmd[7] ? 0 : 1);
      if ((cmd[7] || k > 0) && idx < 3) begin
        mreg[idx] = q[k];
      end
    end
    i_ckg_bus_master.stop();
  endtask
  task automatic reg_read(logic [7:0] cmd, int n);
    logic [8:0] r;
    logic [7:0] e;
    int         idx;
    head(cmd);
    i_ckg_bus_master.start();
    wb(ckg_pkg::TARGET_ADDR8 | 8'h01, 1'b1);
    for (int k = 0; k < n; k++) begin
      i_ckg_bus_master.bits({8'hff, k == n - 1}, r);
      idx = cmd[6:0] + k - (cmd[7] ? 0 : 1);
      e = (!cmd[7] && k == 0) ? 8'h03 : (idx < 3 ? mreg[idx] : 8'h00);
      chk("read", {8'h0, r[8:1]}, {8'h0, e});
    end
    i_ckg_bus_master.stop();
  endtask
  // Six output cycles plus synchronisers fit in 56 clocks; two output periods follow for the look.
  task automatic chk_out();
    logic [8:0] seen;
    logic [8:0] exp;
    seen = 9'h000;
    exp = {mreg[2][3] & g68, mreg[2][4] & g68, mreg[2][5] & g68, mreg[2][6] & g45, mreg[2][7] & g45,
           mreg[1][0] & oe_pin[3], mreg[1][1] & oe_pin[2], mreg[1][2] & oe_pin[1], mreg[1][4] & oe_pin[0]};
    exp = exp & {9{good & pwr}};
    repeat (56) @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      seen = seen | clk_out;
    end
    chk("clk_out", {7'h0, seen}, {7'h0, exp});
    chk("spread_down_en", {15'h0, spread_down_en}, {15'h0, spread});
    chk("osc_enable", {15'h0, osc_enable}, {15'h0, ~good | pwr});
    #1;
  endtask

  // The full sequence takes about 84,000 clocks; the limit at 95,000 clocks leaves some slack.
  initial begin
    #950_000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk_out();
    reg_read(8'h81, 1);
    pwr = 1'b1;
    good = 1'b1;
    chk_out();
    reg_read(8'h00, 4);
    addr_only(8'hd4, 1'b0);
    rnd = $random(seed);
    reg_write(8'h81, {rnd[7:0]});
    reg_read(8'h81, 1);
    chk_out();
    rnd = $random(seed);
    reg_write(8'h00, {8'h03, rnd[7:0], rnd[15:8], rnd[23:16]});
    reg_read(8'h00, 4);
    reg_read(8'h82, 1);
    for (int k = 0; k < 4; k++) begin
      rnd = $random(seed);
      {g68, g45, oe_pin, spread} = rnd[6:0];
      chk_out();
    end
    {g68, g45, oe_pin} = 6'h3f;
    chk_out();
    pwr = 1'b0;
    chk_out();
    addr_only(8'hd6, 1'b0);
    pwr = 1'b1;
    chk_out();
    reg_read(8'h00, 2);
    wrap_up();
  end
endmodule
